/* File: rtl/otpif_pkg.sv */
/*
  Package for the one-time-programmable memory interface block: register
  offsets, field positions, reset values, array load locations and timing.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package otpif_pkg;

  // Register byte offsets
  localparam logic [7:0] OTPIF_OFS_PROG_DATA = 8'h00;
  localparam logic [7:0] OTPIF_OFS_LOC_SEL   = 8'h04;
  localparam logic [7:0] OTPIF_OFS_CONFIG    = 8'h08;
  localparam logic [7:0] OTPIF_OFS_PROGRESS  = 8'h0C;
  localparam logic [7:0] OTPIF_OFS_FETCHED   = 8'h10;
  localparam logic [7:0] OTPIF_OFS_SPECIAL   = 8'h14;
  localparam logic [7:0] OTPIF_OFS_IRQ_MASK  = 8'h18;
  localparam logic [7:0] OTPIF_OFS_RX_TUNE   = 8'h1C;
  localparam logic [7:0] OTPIF_OFS_REG_TUNE  = 8'h20;
  localparam logic [7:0] OTPIF_OFS_PARAM_SET = 8'h24;

  // Array geometry
  localparam int          OTPIF_ADDR_W  = 11;
  localparam int          OTPIF_DEPTH   = 128;
  localparam int          OTPIF_IDX_W   = 7;

  // Configuration field positions
  localparam int OTPIF_CFG_MAN      = 0;
  localparam int OTPIF_CFG_READ     = 1;
  localparam int OTPIF_CFG_WRITE    = 2;
  localparam int OTPIF_CFG_WMODE    = 3;
  localparam int OTPIF_CFG_RXKICK   = 6;
  localparam int OTPIF_CFG_REGKICK  = 7;
  localparam int OTPIF_CFG_OPSKICK  = 10;
  localparam int OTPIF_CFG_OPSSEL_L = 11;
  localparam int OTPIF_CFG_RXSEL    = 13;

  // Status bit positions
  localparam int OTPIF_ST_PROG_DONE = 0;
  localparam int OTPIF_ST_READ_DONE = 1;
  localparam int OTPIF_ST_LOAD_DONE = 2;
  localparam int OTPIF_ST_PROG_ERR  = 3;
  localparam int OTPIF_ST_W         = 4;

  // Reset values
  localparam logic [15:0] OTPIF_CFG_RESET  = 16'h0000;
  localparam logic [15:0] OTPIF_ADDR_RESET = 16'h0000;

  // Array locations of calibration data
  localparam logic [OTPIF_IDX_W-1:0] OTPIF_LOC_RX_CH5 = 7'h20;
  localparam logic [OTPIF_IDX_W-1:0] OTPIF_LOC_RX_CH9 = 7'h34;
  localparam logic [OTPIF_IDX_W-1:0] OTPIF_LOC_REGCAL = 7'h04;
  localparam logic [OTPIF_IDX_W-1:0] OTPIF_LOC_PS_LONG  = 7'h40;
  localparam logic [OTPIF_IDX_W-1:0] OTPIF_LOC_PS_SHORT = 7'h42;

  // Parameter set selector codes
  localparam logic [1:0] OTPIF_PS_LONG  = 2'h0;
  localparam logic [1:0] OTPIF_PS_RSVD  = 2'h1;
  localparam logic [1:0] OTPIF_PS_SHORT = 2'h2;

  // Burn time of one word
  localparam int OTPIF_CLK_HZ       = 10_000_000;
  localparam int OTPIF_PROG_TIME_US = 10;
  localparam int OTPIF_PROG_CYC     = (OTPIF_PROG_TIME_US * (OTPIF_CLK_HZ / 1_000_000) > 0) ?
                                      OTPIF_PROG_TIME_US * (OTPIF_CLK_HZ / 1_000_000) : 1;

endpackage

/* File: rtl/otpif_array.sv */
/*
  Storage model of the one-time-programmable array: one read port with a
  registered output and one word-wide burn port.  A burn only ever sets bits
  and is refused on a location already burned.
  Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module otpif_array #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 128,
  parameter int IDX_W = 7
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Read port
  input  wire logic             rd_en_i,
  input  wire logic [IDX_W-1:0] rd_idx_i,
  output logic      [WIDTH-1:0] rd_data_o,
  // Burn port
  input  wire logic             burn_en_i,
  input  wire logic [IDX_W-1:0] burn_idx_i,
  input  wire logic [WIDTH-1:0] burn_data_i,
  output logic                  burn_refused_o
);

  logic [WIDTH-1:0] cell_q [DEPTH];
  logic [DEPTH-1:0] used_q;

  // Burn refused on a location already programmed
  wire burn_ok = burn_en_i && !used_q[burn_idx_i];

  // Cells hold no reset, as real fuses would not
  always_ff @(posedge clk_i) begin
    if (burn_ok) begin
      cell_q[burn_idx_i] <= burn_data_i;
    end
  end

  // Used flags, cleared only at reset as stand-in for a blank array
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      used_q <= '0;
    end else if (burn_ok) begin
      used_q[burn_idx_i] <= 1'b1;
    end
  end

  // Registered read, blank cells read zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o      <= '0;
      burn_refused_o <= 1'b0;
    end else begin
      burn_refused_o <= burn_en_i && used_q[burn_idx_i];
      if (rd_en_i) begin
        rd_data_o <= used_q[rd_idx_i] ? cell_q[rd_idx_i] : '0;
      end
    end
  end

endmodule

/* File: rtl/otpif_top.sv */
/*
  Register interface to the one-time-programmable memory: program data,
  location select, configuration, status with interrupt, read data and the
  tune values loaded from the array.
  Assumes an Avalon-MM master on the same 10 MHz clock.
*/
`timescale 1ns/1ps
// What this block does
// - Burned locations cannot be changed again until a reset clears the used flags
// - Programming always burns a full 32-bit word
// - Ten sub-registers decoded at 0x00 to 0x24
// - Program data register is 32-bit read-write
// - Location field bits 10:0, reset zero
// - Location register 16 bits, upper bits reserved
// - Config bit 0 selects manual host control
// - Config bit 1 commands an array read
// - Config bit 2 commands an array burn
// - Config 16 bits, cleared at reset, triggers loads
// - Bit 6 loads receiver tune, channel by bit 13
// - Bit 7 loads regulator calibration from 0x4
// - Bit 10 loads selected parameter set
// - Status bit 0 flags programming complete
module otpif_top
  import otpif_pkg::*;
#(
  parameter int PROG_CYC = OTPIF_PROG_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic [1:0]       avs_response_o,
  output logic             avs_waitrequest_o,
  // Interrupt and loaded tune values
  output logic             irq_o,
  output logic [31:0]      rx_tune_o,
  output logic [31:0]      regulator_tune_o,
  output logic [31:0]      param_set_o
);

  typedef enum logic [2:0] {
    OTPIF_IDLE,
    OTPIF_RD_WAIT,
    OTPIF_RD_TAKE,
    OTPIF_BURN,
    OTPIF_LD_WAIT,
    OTPIF_LD_TAKE
  } otpif_state_t;

  typedef enum logic [1:0] {
    OTPIF_DST_RX,
    OTPIF_DST_REG,
    OTPIF_DST_PS
  } otpif_dst_t;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  otpif_state_t     state_q;
  otpif_dst_t       dst_q;
  logic [31:0]      prog_data_q;
  logic [15:0]      loc_sel_q;
  logic [15:0]      cfg_q;
  logic [OTPIF_ST_W-1:0] status_q;
  logic [OTPIF_ST_W-1:0] mask_q;
  logic [31:0]      fetched_q;
  logic [31:0]      special_q;
  logic [31:0]      timer_q;
  logic             ack_q;
  logic [31:0]      arr_rdata;
  logic             arr_refused;

  // Bus decode
  wire acc        = (avs_read_i || avs_write_i) && !ack_q;
  wire wr         = avs_write_i && !ack_q;
  wire sel_prog   = avs_address_i == OTPIF_OFS_PROG_DATA;
  wire sel_loc    = avs_address_i == OTPIF_OFS_LOC_SEL;
  wire sel_cfg    = avs_address_i == OTPIF_OFS_CONFIG;
  wire sel_stat   = avs_address_i == OTPIF_OFS_PROGRESS;
  wire sel_fetch  = avs_address_i == OTPIF_OFS_FETCHED;
  wire sel_spec   = avs_address_i == OTPIF_OFS_SPECIAL;
  wire sel_mask   = avs_address_i == OTPIF_OFS_IRQ_MASK;
  wire sel_rxt    = avs_address_i == OTPIF_OFS_RX_TUNE;
  wire sel_regt   = avs_address_i == OTPIF_OFS_REG_TUNE;
  wire sel_ps     = avs_address_i == OTPIF_OFS_PARAM_SET;
  wire mapped     = sel_prog | sel_loc | sel_cfg | sel_stat | sel_fetch | sel_spec |
                    sel_mask | sel_rxt | sel_regt | sel_ps;
  wire busy       = state_q != OTPIF_IDLE;

  // Config write and the commands it carries
  wire        cfg_wr   = wr && sel_cfg;
  wire [31:0] cfg_new  = merge({16'h0000, cfg_q}, avs_writedata_i, avs_byteenable_i);
  wire        man      = cfg_new[OTPIF_CFG_MAN];
  wire        go_read  = cfg_wr && man && cfg_new[OTPIF_CFG_READ];
  wire        go_burn  = cfg_wr && man && cfg_new[OTPIF_CFG_WRITE];
  wire        go_rx    = cfg_wr && cfg_new[OTPIF_CFG_RXKICK];
  wire        go_reg   = cfg_wr && cfg_new[OTPIF_CFG_REGKICK];
  wire [1:0]  ps_sel   = cfg_new[OTPIF_CFG_OPSSEL_L +: 2];
  wire        go_ps    = cfg_wr && cfg_new[OTPIF_CFG_OPSKICK] && (ps_sel != OTPIF_PS_RSVD);
  wire        start    = !busy && (go_read || go_burn || go_rx || go_reg || go_ps);

  // Location of a load, by trigger priority rx, regulator, parameter set
  wire [OTPIF_IDX_W-1:0] rx_loc  = cfg_new[OTPIF_CFG_RXSEL] ? OTPIF_LOC_RX_CH9 : OTPIF_LOC_RX_CH5;
  wire [OTPIF_IDX_W-1:0] ps_loc  = (ps_sel == OTPIF_PS_LONG) ? OTPIF_LOC_PS_LONG : OTPIF_LOC_PS_SHORT;
  wire [OTPIF_IDX_W-1:0] ld_loc  = go_rx ? rx_loc : (go_reg ? OTPIF_LOC_REGCAL : ps_loc);
  wire [OTPIF_IDX_W-1:0] usr_loc = loc_sel_q[OTPIF_IDX_W-1:0];
  wire                   in_rd   = !busy && (go_read || (!go_burn && (go_rx || go_reg || go_ps)));
  wire [OTPIF_IDX_W-1:0] rd_idx  = go_read ? usr_loc : ld_loc;
  wire                   burn_en = !busy && go_burn && !go_read;

  // Status events
  wire                  prog_done = (state_q == OTPIF_BURN) && (timer_q == 32'd1);
  wire [OTPIF_ST_W-1:0] ev;
  assign ev[OTPIF_ST_PROG_DONE] = prog_done;
  assign ev[OTPIF_ST_READ_DONE] = state_q == OTPIF_RD_TAKE;
  assign ev[OTPIF_ST_LOAD_DONE] = state_q == OTPIF_LD_TAKE;
  assign ev[OTPIF_ST_PROG_ERR]  = arr_refused;
  wire [OTPIF_ST_W-1:0] w1c = (wr && sel_stat) ? avs_writedata_i[OTPIF_ST_W-1:0] : '0;

  // Read data mux
  wire [31:0] rd_mux = sel_prog  ? prog_data_q :
                       sel_loc   ? {16'h0000, loc_sel_q} :
                       sel_cfg   ? {16'h0000, cfg_q} :
                       sel_stat  ? {{(32-OTPIF_ST_W){1'b0}}, status_q} :
                       sel_fetch ? fetched_q :
                       sel_spec  ? special_q :
                       sel_mask  ? {{(32-OTPIF_ST_W){1'b0}}, mask_q} :
                       sel_rxt   ? rx_tune_o :
                       sel_regt  ? regulator_tune_o :
                       sel_ps    ? param_set_o : 32'h0000_0000;

  otpif_array #(
    .WIDTH (32),
    .DEPTH (OTPIF_DEPTH),
    .IDX_W (OTPIF_IDX_W)
  ) u_array (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .rd_en_i        (in_rd),
    .rd_idx_i       (rd_idx),
    .rd_data_o      (arr_rdata),
    .burn_en_i      (burn_en),
    .burn_idx_i     (usr_loc),
    .burn_data_i    (prog_data_q),
    .burn_refused_o (arr_refused)
  );

  // Bus answer: one wait cycle, then acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      avs_response_o    <= 2'h0;
    end else begin
      ack_q             <= acc;
      avs_waitrequest_o <= !acc;
      avs_readdata_o    <= (acc && avs_read_i) ? rd_mux : 32'h0000_0000;
      avs_response_o    <= (acc && !mapped) ? 2'h3 : 2'h0;  // Unmapped decodes as an error
    end
  end

  // Software-written registers; writes land in the acknowledge cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_data_q <= 32'h0000_0000;
      loc_sel_q   <= OTPIF_ADDR_RESET;
      mask_q      <= '0;
    end else if (wr) begin
      if (sel_prog) begin
        prog_data_q <= merge(prog_data_q, avs_writedata_i, avs_byteenable_i);
      end
      if (sel_loc) begin
        loc_sel_q <= {5'h00, cfg_trim(merge(32'h0, avs_writedata_i, avs_byteenable_i))};
      end
      if (sel_mask) begin
        mask_q <= avs_writedata_i[OTPIF_ST_W-1:0];
      end
    end
  end

  // Keep the 11-bit location field, reserved bits read zero
  function automatic logic [OTPIF_ADDR_W-1:0] cfg_trim(input logic [31:0] v);
    return v[OTPIF_ADDR_W-1:0];
  endfunction

  // Configuration: triggers self-clear once a sequence is taken
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= OTPIF_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_new[15:0] & ~(start ? 16'h04C6 : 16'h0000);
    end
  end

  // Sticky status, set wins over write-one-clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c) | ev;
      irq_o    <= |(((status_q & ~w1c) | ev) & mask_q);
    end
  end

  // Sequencer for reads, burns and loads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= OTPIF_IDLE;
      dst_q   <= OTPIF_DST_RX;
      timer_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        OTPIF_IDLE: begin
          if (in_rd && go_read) begin
            state_q <= OTPIF_RD_WAIT;
          end else if (burn_en) begin
            state_q <= OTPIF_BURN;
            timer_q <= 32'(PROG_CYC);
          end else if (in_rd) begin
            state_q <= OTPIF_LD_WAIT;
            dst_q   <= go_rx ? OTPIF_DST_RX : (go_reg ? OTPIF_DST_REG : OTPIF_DST_PS);
          end
        end
        OTPIF_RD_WAIT: state_q <= OTPIF_RD_TAKE;
        OTPIF_LD_WAIT: state_q <= OTPIF_LD_TAKE;
        OTPIF_BURN: begin
          timer_q <= timer_q - 32'd1;
          if (timer_q <= 32'd1) begin
            state_q <= OTPIF_IDLE;
          end
        end
        default: state_q <= OTPIF_IDLE;
      endcase
    end
  end

  // Loaded words land in their destination registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetched_q        <= 32'h0000_0000;
      special_q        <= 32'h0000_0000;
      rx_tune_o        <= 32'h0000_0000;
      regulator_tune_o <= 32'h0000_0000;
      param_set_o      <= 32'h0000_0000;
    end else if (state_q == OTPIF_RD_TAKE) begin
      fetched_q <= arr_rdata;
    end else if (state_q == OTPIF_LD_TAKE) begin
      special_q <= arr_rdata;
      case (dst_q)
        OTPIF_DST_RX:  rx_tune_o        <= arr_rdata;
        OTPIF_DST_REG: regulator_tune_o <= arr_rdata;
        default:       param_set_o      <= arr_rdata;
      endcase
    end
  end

endmodule

/* File: tb/otpif_assertions.sv */
/*
  Bus checker for the memory interface block.
  Assumes it is bound to otpif_top and sees its ports only.
*/
`timescale 1ns/1ps
module otpif_checker
  import otpif_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // Register bus
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        avs_waitrequest_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Request and acknowledge terms
  wire logic req    = avs_read_i | avs_write_i;
  wire logic ack    = req & !avs_waitrequest_o;
  wire logic rd_ack = avs_read_i & !avs_waitrequest_o;

  a_ack_next_cycle: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("acknowledge late");
  a_ack_one_only: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("acknowledge held");
  a_ack_needs_req: assert property (!avs_waitrequest_o |-> $past(req))
    else $error("acknowledge without request");
  a_idle_data_zero: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
    else $error("read data outside acknowledge");
  a_unmapped_read: assert property (rd_ack && avs_address_i > 8'h24 |->
    avs_response_o == 2'h3 && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (
    ack && avs_address_i <= 8'h24 && avs_address_i[1:0] == 2'h0 |-> avs_response_o == 2'h0)
    else $error("mapped access refused");
  a_loc_width: assert property (rd_ack && avs_address_i == OTPIF_OFS_LOC_SEL |->
    avs_readdata_o[31:11] == 21'h0)
    else $error("location register too wide");
  a_cfg_width: assert property (rd_ack && avs_address_i == OTPIF_OFS_CONFIG |->
    avs_readdata_o[31:16] == 16'h0)
    else $error("configuration too wide");
  a_status_width: assert property (rd_ack && avs_address_i == OTPIF_OFS_PROGRESS |->
    avs_readdata_o[31:OTPIF_ST_W] == '0)
    else $error("status bits out of range");
endmodule
bind otpif_top otpif_checker u_chk (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_response_o, .avs_waitrequest_o);

/* File: tb/otpif_host.sv */
/*
  Host model: one Avalon-MM transfer per go pulse.
  Assumes the bench waits for busy to drop before the next go.
*/
`timescale 1ns/1ps
module otpif_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Command from the bench
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic             busy_o,
  output logic [31:0]      rdat_o,
  output logic [1:0]       resp_o,
  // Avalon-MM master
  output logic [7:0]       avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic [3:0]       avs_byteenable_o,
  output logic [31:0]      avs_writedata_o,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic [1:0]  avs_response_i,
  input  wire logic        avs_waitrequest_i
);
  // Whole words only, so every lane enabled
  assign avs_byteenable_o = 4'hF;
  // Request held until waitrequest is sampled low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o          <= 1'b0;
      avs_read_o      <= 1'b0;
      avs_write_o     <= 1'b0;
      avs_address_o   <= 8'h00;
      avs_writedata_o <= 32'h0;
      rdat_o          <= 32'h0;
      resp_o          <= 2'h0;
    end else if (!busy_o && go_i) begin
      busy_o          <= 1'b1;
      avs_read_o      <= !wr_i;
      avs_write_o     <= wr_i;
      avs_address_o   <= adr_i;
      avs_writedata_o <= dat_i;
    end else if (busy_o && !avs_waitrequest_i) begin
      busy_o      <= 1'b0;
      avs_read_o  <= 1'b0;
      avs_write_o <= 1'b0;
      rdat_o      <= avs_readdata_i;
      resp_o      <= avs_response_i;
    end
  end
endmodule

/* File: tb/otpif_top_test.sv */
/*
  Self-checking bench for the memory interface block.
  Assumes otpif_host speaks the register bus on its behalf.
*/
`timescale 1ns/1ps
module otpif_top_test;
  import otpif_pkg::*;
  logic        clk_i, reset_n_i, go, wr, busy, rd_en, wr_en, wait_r, irq;
  logic [7:0]  adr, b_adr;
  logic [31:0] dat, rdat, b_wd, b_rd, rx_t, rg_t, ps_t, got;
  logic [1:0]  resp, b_resp;
  logic [3:0]  b_be;
  int          fails, check_count, cyc;
  logic [6:0]  li [5] = '{7'h04, 7'h20, 7'h34, 7'h40, 7'h42};
  logic [15:0] lk [5] = '{16'h0080, 16'h0040, 16'h2040, 16'h0400, 16'h1400};

  otpif_top #(.PROG_CYC(2)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(b_adr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_byteenable_i(b_be), .avs_writedata_i(b_wd),
    .avs_readdata_o(b_rd), .avs_response_o(b_resp), .avs_waitrequest_o(wait_r), .irq_o(irq),
    .rx_tune_o(rx_t), .regulator_tune_o(rg_t), .param_set_o(ps_t));
  otpif_host u_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .wr_i(wr), .adr_i(adr),
    .dat_i(dat), .busy_o(busy), .rdat_o(rdat), .resp_o(resp), .avs_address_o(b_adr),
    .avs_read_o(rd_en), .avs_write_o(wr_en), .avs_byteenable_o(b_be), .avs_writedata_o(b_wd),
    .avs_readdata_i(b_rd), .avs_response_i(b_resp), .avs_waitrequest_i(wait_r));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One transfer; busy sampled on the falling edge, clear of the updates
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    go <= 1'b1;
    wr <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    go <= 1'b0;
    @(negedge clk_i);
    while (busy) @(negedge clk_i);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  // Read status until a bit of m shows
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    xfer(1'b0, OTPIF_OFS_PROGRESS, 32'h0);
    while ((rdat & m) == 32'h0 && n < 50) begin
      xfer(1'b0, OTPIF_OFS_PROGRESS, 32'h0);
      n++;
    end
  endtask
  task automatic burn(input logic [6:0] i, input logic [31:0] d);
    xfer(1'b1, OTPIF_OFS_PROGRESS, 32'hF);
    xfer(1'b1, OTPIF_OFS_PROG_DATA, d);
    xfer(1'b1, OTPIF_OFS_LOC_SEL, {25'h0, i});
    xfer(1'b1, OTPIF_OFS_CONFIG, 32'h5);
    poll(32'h9);
  endtask
  task automatic fetch(input string n, input logic [31:0] e);
    xfer(1'b1, OTPIF_OFS_CONFIG, 32'h3);
    poll(32'h2);
    rd_chk(n, OTPIF_OFS_FETCHED, e);
  endtask

  initial begin
    reset_n_i = 1'b0; go = 1'b0; wr = 1'b0; adr = 8'h00; dat = 32'h0;
    fails = 0; check_count = 0; cyc = 0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk("cfg", OTPIF_OFS_CONFIG, 32'h0);
    rd_chk("loc", OTPIF_OFS_LOC_SEL, 32'h0);
    xfer(1'b1, OTPIF_OFS_PROG_DATA, 32'hA55A_0FF0);
    rd_chk("pdata", OTPIF_OFS_PROG_DATA, 32'hA55A_0FF0);
    xfer(1'b1, OTPIF_OFS_LOC_SEL, 32'hFFFF_FFFF);
    rd_chk("loc", OTPIF_OFS_LOC_SEL, 32'h0000_07FF);
    rd_chk("unmapped", 8'h3C, 32'h0);
    chk("resp", 32'h3, {30'h0, resp});
    $display("test registers done");
    burn(7'h05, 32'h1234_5678);
    rd_chk("done", OTPIF_OFS_PROGRESS, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, OTPIF_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b1, OTPIF_OFS_PROGRESS, 32'hF);
    repeat (2) @(negedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq});
    fetch("fetch", 32'h1234_5678);
    burn(7'h05, 32'hFFFF_0000);
    chk("refused", 32'h1, {31'h0, rdat[OTPIF_ST_PROG_ERR]});
    fetch("kept", 32'h1234_5678);
    $display("test burn and read done");
    for (int k = 0; k < 5; k++) begin
      burn(li[k], 32'hC0DE_0000 + k);
      xfer(1'b1, OTPIF_OFS_CONFIG, {16'h0, lk[k]});
      poll(32'h4);
      got = (k == 0) ? rg_t : (k < 3) ? rx_t : ps_t;
      chk("load", 32'hC0DE_0000 + k, got);
    end
    rd_chk("special", OTPIF_OFS_SPECIAL, 32'hC0DE_0004);
    rd_chk("rx tune", OTPIF_OFS_RX_TUNE, 32'hC0DE_0002);
    xfer(1'b1, OTPIF_OFS_CONFIG, 32'h0C00);
    repeat (10) @(negedge clk_i);
    chk("reserved set", 32'hC0DE_0004, ps_t);
    $display("test loads done");
    conclude();
  end
endmodule
